// >>> afc_pkg.sv
`default_nettype none
package afc_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0]  CONFIG_ADDR     = 8'h2C;
  localparam logic [7:0]  AFC_STAT_ADDR   = 8'h04;
  localparam logic [31:0] CONFIG_RST      = 32'h0000_0000;

  // Field positions in auto_flow_control_config
  localparam int HI_LSB   = 16;
  localparam int LO_LSB   = 8;
  localparam int DUR_LSB  = 4;
  localparam int MULT_BIT = 3;
  localparam int BRD_BIT  = 2;
  localparam int ADDR_BIT = 1;
  localparam int ANY_BIT  = 0;
  localparam int CFG_USED_BYTES = 3;

  // Status register bit positions
  localparam int ST_JAM    = 0;
  localparam int ST_REQ    = 1;
  localparam int ST_ZERO   = 2;
  localparam int ST_PAUSED = 3;
  localparam int ST_HI     = 4;
  localparam int ST_BELOW  = 5;

  // FIFO level unit is 64 bytes
  localparam int LVL_SHIFT = 6;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int BP_T0_NS        = 5000;
  localparam int BP_T1_NS        = 10000;
  localparam int BP_T2_NS        = 15000;
  localparam int BP_T3_NS        = 25000;
  localparam int BP_STEP_NS      = 50000;
  localparam int BP_STEP_BASE    = 3;
  localparam int BP_10M_EXTRA_NS = 2200;
  localparam int BP_MAX_NS       = 600000;

  typedef enum logic [1:0] {
    FC_IDLE, FC_HI_REQ, FC_PAUSED, FC_ZERO_REQ
  } afc_fc_state_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } afc_wb_req_s;

  typedef struct packed {
    logic preamble;
    logic da_valid;
    logic is_mcast;
    logic is_bcast;
    logic addr_match;
  } afc_rx_ev_s;

endpackage
`default_nettype wire

// >>> afc_trigger.sv
`default_nettype none
module afc_trigger
  import afc_pkg::*;
#(
  parameter int FIFO_W   = 14,
  parameter int TMR_W    = 16,
  parameter int DUR_SHIFT = 0
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire afc_pkg::afc_wb_req_s wb_req_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // MAC status
  input  wire logic                 fdx_i,
  input  wire logic                 speed10_i,
  input  wire logic                 tx_en_i,
  input  wire logic [FIFO_W-1:0]    fifo_used_i,
  input  wire afc_pkg::afc_rx_ev_s  rx_ev_i,
  // MAC requests
  output logic                      jam_o,
  output logic                      pause_req_o,
  output logic                      pause_zero_o,
  input  wire logic                 pause_ack_i
);
  import afc_pkg::*;

  // ------------------------------------------------------------
  // Duration arithmetic
  // ------------------------------------------------------------
  function automatic int unsigned dur_ns(input logic [3:0] code,
                                         input logic       slow);
    int unsigned ns;
    case (code)
      4'h0: ns = BP_T0_NS;
      4'h1: ns = BP_T1_NS;
      4'h2: ns = BP_T2_NS;
      4'h3: ns = BP_T3_NS;
      default: ns = BP_STEP_NS * (int'(code) - BP_STEP_BASE);
    endcase
    if (slow) begin
      ns = ns + BP_10M_EXTRA_NS;
    end
    return ns;
  endfunction

  function automatic logic [TMR_W-1:0] ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns / CLK_PERIOD_NS) >> DUR_SHIFT;
    if (c == 0) begin
      c = 1;
    end
    return TMR_W'(c);
  endfunction

  // ------------------------------------------------------------
  // Configuration register
  // ------------------------------------------------------------
  logic [31:0]   cfg_r;
  logic          ack_r;
  logic [31:0]   rdat_r;
  logic          wr_go;
  logic [31:0]   status;

  wire  [7:0] hi_th    = cfg_r[HI_LSB +: 8];
  wire  [7:0] lo_th    = cfg_r[LO_LSB +: 8];
  wire  [3:0] dur_sel  = cfg_r[DUR_LSB +: 4];
  wire        q_mult   = cfg_r[MULT_BIT];
  wire        q_brd    = cfg_r[BRD_BIT];
  wire        q_addr   = cfg_r[ADDR_BIT];
  wire        q_any    = cfg_r[ANY_BIT];

  // Write lands on the edge where the master sees ack
  assign wr_go = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= CONFIG_RST;
    end else if (wr_go && wb_req_i.adr == CONFIG_ADDR) begin
      // Top byte is reserved and stays zero
      for (int b = 0; b < CFG_USED_BYTES; b++) begin
        if (wb_req_i.sel[b]) begin
          cfg_r[b*8 +: 8] <= wb_req_i.dat[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req_i.cyc && wb_req_i.stb && !ack_r;
    end
  end

  // Unmapped addresses are acknowledged and read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= 32'h0000_0000;
    end else if (wb_req_i.cyc && wb_req_i.stb && !ack_r) begin
      if (wb_req_i.adr == CONFIG_ADDR) begin
        rdat_r <= cfg_r;
      end else if (wb_req_i.adr == AFC_STAT_ADDR) begin
        rdat_r <= status;
      end else begin
        rdat_r <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ------------------------------------------------------------
  // Threshold compare
  // ------------------------------------------------------------
  logic          lvl_hi;
  logic          below_lo;
  int unsigned   units;

  always_comb begin
    units    = 32'(fifo_used_i >> LVL_SHIFT);
    lvl_hi   = units >= 32'(hi_th);
    below_lo = units <  32'(lo_th);
  end

  // ------------------------------------------------------------
  // Half-duplex back pressure
  // ------------------------------------------------------------
  logic             trig_hd;
  logic             qual_hit;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] load_val;

  always_comb begin
    if (q_any) begin
      qual_hit = rx_ev_i.preamble;
    end else begin
      qual_hit = rx_ev_i.da_valid &&
                 ((q_mult && rx_ev_i.is_mcast) ||
                  (q_brd  && rx_ev_i.is_bcast) ||
                  (q_addr && rx_ev_i.addr_match));
    end
    trig_hd  = !fdx_i && tx_en_i && lvl_hi && qual_hit;
    load_val = ns_to_cyc(dur_ns(dur_sel, speed10_i));
  end

  // A new qualifying frame restarts the full period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_r <= '0;
    end else if (trig_hd) begin
      tmr_r <= load_val;
    end else if (fdx_i) begin
      tmr_r <= '0;
    end else if (tmr_r != '0) begin
      tmr_r <= tmr_r - TMR_W'(1);
    end
  end

  assign jam_o = (tmr_r != '0);

  // ------------------------------------------------------------
  // Full-duplex pause requests
  // ------------------------------------------------------------
  afc_fc_state_e st_r;
  logic          fd_en;
  logic          zero_r;

  assign fd_en = fdx_i && q_any && tx_en_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= FC_IDLE;
    end else begin
      case (st_r)
        FC_IDLE: begin
          if (fd_en && lvl_hi) begin
            st_r <= FC_HI_REQ;
          end
        end
        FC_HI_REQ: begin
          if (pause_ack_i) begin
            st_r <= FC_PAUSED;
          end
        end
        FC_PAUSED: begin
          if (!fd_en) begin
            st_r <= FC_IDLE;
          end else if (below_lo) begin
            st_r <= FC_ZERO_REQ;
          end
        end
        FC_ZERO_REQ: begin
          if (pause_ack_i) begin
            st_r <= FC_IDLE;
          end
        end
        default: st_r <= FC_IDLE;
      endcase
    end
  end

  // Request is held until the MAC takes it; one per threshold crossing
  assign pause_req_o = (st_r == FC_HI_REQ) || (st_r == FC_ZERO_REQ);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zero_r <= 1'b0;
    end else if (st_r == FC_PAUSED && fd_en && below_lo) begin
      zero_r <= 1'b1;
    end else if (st_r == FC_IDLE) begin
      zero_r <= 1'b0;
    end
  end

  assign pause_zero_o = zero_r;

  always_comb begin
    status            = 32'h0000_0000;
    status[ST_JAM]    = jam_o;
    status[ST_REQ]    = pause_req_o;
    status[ST_ZERO]   = zero_r;
    status[ST_PAUSED] = (st_r == FC_PAUSED);
    status[ST_HI]     = lvl_hi;
    status[ST_BELOW]  = below_lo;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_dur_code0_fast: assert property (
    trig_hd && !speed10_i && dur_sel == 4'h0 |=>
      tmr_r == ns_to_cyc(BP_T0_NS))
    else $error("jam period wrong for code 0 at 100M");

  a_dur_codeF_slow: assert property (
    trig_hd && speed10_i && dur_sel == 4'hF |=>
      tmr_r == ns_to_cyc(BP_MAX_NS + BP_10M_EXTRA_NS))
    else $error("jam period wrong for code F at 10M");

  a_speed_at_start: assert property (
    trig_hd && dur_sel == 4'h0 |=>
      tmr_r == ($past(speed10_i) ? ns_to_cyc(BP_T0_NS + BP_10M_EXTRA_NS)
                                 : ns_to_cyc(BP_T0_NS)))
    else $error("timer not loaded from current speed table");

  a_mcast_jam: assert property (
    !fdx_i && tx_en_i && lvl_hi && !q_any && q_mult &&
    rx_ev_i.da_valid && rx_ev_i.is_mcast |=> jam_o)
    else $error("multicast frame not jammed");

  a_bcast_jam: assert property (
    !fdx_i && tx_en_i && lvl_hi && !q_any && q_brd &&
    rx_ev_i.da_valid && rx_ev_i.is_bcast |=> jam_o)
    else $error("broadcast frame not jammed");

  a_addr_jam: assert property (
    !fdx_i && tx_en_i && lvl_hi && !q_any && q_addr &&
    rx_ev_i.da_valid && rx_ev_i.addr_match |=> jam_o)
    else $error("addressed frame not jammed");

  a_preamble_jam: assert property (
    !fdx_i && tx_en_i && lvl_hi && q_any && rx_ev_i.preamble
    |=> jam_o)
    else $error("preamble did not start jam");

  a_any_overrides: assert property (
    !fdx_i && tx_en_i && lvl_hi && q_any && !jam_o &&
    rx_ev_i.da_valid && !rx_ev_i.preamble |=> !jam_o)
    else $error("qualifier bits used while any-frame set");

  a_fdx_no_jam: assert property (
    fdx_i |=> !jam_o)
    else $error("jam in full duplex");

  a_pause_on_hi: assert property (
    st_r == FC_IDLE && fd_en && lvl_hi |=>
      pause_req_o && !pause_zero_o)
    else $error("pause not requested at high level");

  a_req_held: assert property (
    pause_req_o && !pause_ack_i && fd_en |=> pause_req_o)
    else $error("pause request dropped before ack");

  a_single_pause: assert property (
    st_r == FC_PAUSED && !below_lo |=> !pause_req_o)
    else $error("second pause for one crossing");

  a_zero_pause: assert property (
    st_r == FC_PAUSED && fd_en && below_lo |=>
      pause_req_o && pause_zero_o)
    else $error("zero pause not requested below low level");

  c_jam_run:   cover property (trig_hd ##1 jam_o [*3]);
  c_pause:     cover property (st_r == FC_HI_REQ && pause_ack_i);
  c_zero:      cover property (st_r == FC_ZERO_REQ && pause_ack_i);
  c_cfg_write: cover property (wr_go && wb_req_i.adr == CONFIG_ADDR);

endmodule
`default_nettype wire

// >>> afc_mac_model.sv
`default_nettype none
module afc_mac_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Pause handshake with the trigger block
  input  wire logic       pause_req_i,
  input  wire logic [3:0] delay_i,
  output logic            pause_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] wait_r;

  // Transmit window opens delay_i cycles after the request is seen; the
  // ack is a single pulse, and a request still held after it is counted again and acked a second time
  always_ff @(posedge clk_i) begin
    if (rst_i || !pause_req_i || pause_ack_o) begin
      wait_r      <= 4'h0;
      pause_ack_o <= 1'b0;
    end else if (wait_r == delay_i) begin
      pause_ack_o <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import afc_pkg::*;

  logic        clk_i, rst_i, fdx, spd10, tx_en, ack_in, jam, preq, pzero;
  logic        wb_ack, sp;
  logic [13:0] fifo;
  logic [31:0] wb_dat, rd;
  logic [3:0]  dly;
  afc_wb_req_s wb;
  afc_rx_ev_s  ev;
  int          bad_count, checks_done, n, hi, code, q;

  // Durations shortened by 16 so the longest jam stays near 750 cycles
  afc_trigger #(.FIFO_W(14), .TMR_W(16), .DUR_SHIFT(4)) i_afc_trigger (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb), .wb_dat_o(wb_dat),
    .wb_ack_o(wb_ack), .fdx_i(fdx), .speed10_i(spd10), .tx_en_i(tx_en),
    .fifo_used_i(fifo), .rx_ev_i(ev), .jam_o(jam), .pause_req_o(preq),
    .pause_zero_o(pzero), .pause_ack_i(ack_in));

  afc_mac_model i_afc_mac_model (.clk_i(clk_i), .rst_i(rst_i),
    .pause_req_i(preq), .delay_i(dly), .pause_ack_o(ack_in));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic int exp_len(int c, logic s);
    int ns;
    ns = (c < 3) ? 5000 * (c + 1) : (c == 3) ? 25000 : (c - 3) * 50000;
    if (s) ns += 2200;
    return (ns / 50) >> 4;
  endfunction

  function automatic logic [31:0] cfg(int h, int l, int d, logic [3:0] f);
    return {8'h00, h[7:0], l[7:0], d[3:0], f};
  endfunction

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic bus(logic w, logic [7:0] a, logic [3:0] s, logic [31:0] d);
    @(posedge clk_i);
    wb <= '{cyc:1'b1, stb:1'b1, we:w, adr:a, sel:s, dat:d};
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_dat;
    wb.cyc <= 1'b0;
    wb.stb <= 1'b0;
  endtask

  // Speed flips right after the trigger: the period must not follow it
  task automatic frame(logic [4:0] e, output int cnt);
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    sp = spd10;
    ev <= '0;
    spd10 <= ~spd10;
    cnt = 0;
    @(negedge clk_i);
    while (jam === 1'b1 && cnt < 20000) begin
      cnt++;
      @(negedge clk_i);
    end
    // Return on a rising edge so the caller drives inputs there
    @(posedge clk_i);
  endtask

  task automatic wait_req(logic [31:0] z);
    int k;
    k = 0;
    while (preq !== 1'b1 && k < 50) begin
      @(negedge clk_i);
      k++;
    end
    chk("pause_req_o", 1, preq);
    chk("pause_zero_o", z, pzero);
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    give_verdict();
  end

  initial begin
    rst_i = 1'b1;
    fdx = 1'b0;
    spd10 = 1'b0;
    tx_en = 1'b1;
    fifo = '0;
    ev = '0;
    wb = '0;
    dly = 4'h0;
    bad_count = 0;
    checks_done = 0;
    void'($urandom(43));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, CONFIG_ADDR, 4'hF, 0);
    chk("cfg reset", CONFIG_RST, rd);
    bus(1'b1, CONFIG_ADDR, 4'hF, 32'hFFFF_FFFF);
    bus(1'b0, CONFIG_ADDR, 4'hF, 0);
    chk("cfg rw", 32'h00FF_FFFF, rd);
    bus(1'b1, CONFIG_ADDR, 4'h1, 32'h0000_0000);
    bus(1'b0, CONFIG_ADDR, 4'hF, 0);
    chk("cfg byte lane", 32'h00FF_FF00, rd);
    bus(1'b1, 8'h80, 4'hF, 32'h1234_5678);
    bus(1'b0, 8'h80, 4'hF, 0);
    chk("unmapped read", 0, rd);
    // Every duration code at both speeds, random qualifier and level
    for (int i = 0; i < 32; i++) begin
      code = i / 2;
      hi = $urandom_range(8, 1);
      q = 1 << $urandom_range(3, 1);
      bus(1'b1, CONFIG_ADDR, 4'hF, cfg(hi, 1, code, q[3:0]));
      fifo <= 14'(hi * 64 + $urandom_range(63, 0));
      spd10 <= i[0];
      frame({2'b01, q[3], q[2], q[1]}, n);
      chk("jam length", exp_len(code, sp), n);
    end
    bus(1'b1, CONFIG_ADDR, 4'hF, cfg(4, 2, 0, 4'h8));
    fifo <= 14'd256;
    frame(5'b01010, n);
    chk("jam on other type", 0, n);
    fifo <= 14'd255;
    frame(5'b01100, n);
    chk("jam below level", 0, n);
    fifo <= 14'd256;
    fdx <= 1'b1;
    frame(5'b01100, n);
    chk("jam in full duplex", 0, n);
    chk("pause without any", 0, preq);
    fdx <= 1'b0;
    bus(1'b1, CONFIG_ADDR, 4'hF, cfg(4, 2, 0, 4'h9));
    frame(5'b01100, n);
    chk("jam on address only", 0, n);
    frame(5'b10000, n);
    chk("jam on preamble", exp_len(0, sp), n);
    tx_en <= 1'b0;
    frame(5'b10000, n);
    chk("jam with tx off", 0, n);
    tx_en <= 1'b1;
    fifo <= 14'd0;
    fdx <= 1'b1;
    dly <= 4'($urandom_range(9, 0));
    bus(1'b1, CONFIG_ADDR, 4'hF, cfg(4, 2, 3, 4'h1));
    fifo <= 14'd256;
    wait_req(0);
    repeat (30) @(negedge clk_i);
    chk("second pause", 0, preq);
    chk("jam in full duplex", 0, jam);
    bus(1'b0, AFC_STAT_ADDR, 4'hF, 0);
    chk("status paused", 32'(1 << ST_PAUSED) | 32'(1 << ST_HI), rd);
    fifo <= 14'd127;
    wait_req(1);
    repeat (30) @(negedge clk_i);
    chk("pause after zero", 0, preq);
    give_verdict();
  end
endmodule
`default_nettype wire
